// ---- core/phy_timing_pkg.sv ----
// Shared constants and types for the turnaround timer and quality encoder
package phy_timing_pkg;

  // Clock rate in kHz so that microsecond figures give whole cycle counts
  localparam int CLK_KHZ = 25000;
  // Spacing figures in microseconds
  localparam int SHORT_SPACING_US = 10;
  localparam int MIN_SPACING_US = 2;
  // Cycle counts; exact gaps, so no rounding beyond the division
  localparam int SHORT_SPACING_CYC = SHORT_SPACING_US * CLK_KHZ / 1000;
  localparam int MIN_SPACING_CYC = MIN_SPACING_US * CLK_KHZ / 1000;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] SHORT_GAP = CNT_W'(SHORT_SPACING_CYC);
  localparam logic [CNT_W-1:0] MIN_GAP = CNT_W'(MIN_SPACING_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

  // Turnaround lead time: switching finishes this many cycles plus two after the
  // transmit request, well below the short spacing
  localparam logic [CNT_W-1:0] TURN_CYC = 9'h004;

  // Quality code layout
  localparam int SNR_W = 12;
  localparam int SNR_FRAC = 4;
  localparam logic [7:0] CODE_UNSUP = 8'h00;
  localparam logic [7:0] CODE_MIN = 8'h01;
  localparam logic [7:0] CODE_MAX = 8'h33;
  localparam logic signed [SNR_W-SNR_FRAC:0] DB_LOW = -9'sd10;
  localparam logic signed [SNR_W-SNR_FRAC:0] DB_HIGH = 9'sd40;
  localparam logic [SNR_W-1:0] HALF_DB = 12'h008;

  // Link direction states, Gray along idle->rx->turn->tx
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_RX2TX = 3'h3,
    ST_TX = 3'h2,
    ST_TX2RX = 3'h6,
    ST_GAP = 3'h7
  } link_state_t;

endpackage : phy_timing_pkg

// ---- core/lq_if.sv ----
// Carrier between the timing core and the quality encoder
`timescale 1ns/100ps
interface lq_if;
  import phy_timing_pkg::*;
  logic snr_valid; // One-cycle pulse at packet end
  logic signed [SNR_W-1:0] snr_mean; // Mean SNR, dB with 4 fraction bits
  logic enable; // Reporting supported
  logic code_valid; // Pulse with new code
  logic [7:0] code; // Registered code
  modport core (output snr_valid, snr_mean, enable, input code_valid, code);
  modport enc (input snr_valid, snr_mean, enable, output code_valid, code);
endinterface : lq_if

// ---- core/lq_encoder.sv ----
// Quantizer from mean SNR to the 8-bit link quality code
`timescale 1ns/100ps
module lq_encoder
  import phy_timing_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  lq_if.enc lq
);

  typedef struct packed {
    logic vld;
    logic [7:0] code;
  } enc_state_t;

  enc_state_t s_r; // Registered state
  enc_state_t s_nxt; // Next state
  logic signed [SNR_W-SNR_FRAC:0] db_round; // Tied to zero, never read

  // Round to nearest dB, then clamp and offset
  function automatic logic [7:0] quantize(input logic signed [SNR_W-1:0] v);
    logic signed [SNR_W:0] t;
    logic signed [SNR_W-SNR_FRAC:0] d;
    t = {v[SNR_W-1], v} + $signed({1'b0, HALF_DB});
    d = t[SNR_W:SNR_FRAC];
    if (d <= DB_LOW) begin
      quantize = CODE_MIN;
    end else if (d >= DB_HIGH) begin
      quantize = CODE_MAX;
    end else begin
      quantize = CODE_MIN + 8'(d - DB_LOW);
    end
  endfunction

  assign db_round = '0;

  // Update once per packet
  always_comb begin
    s_nxt = s_r;
    s_nxt.vld = lq.snr_valid;
    if (lq.snr_valid) begin
      if (lq.enable) begin
        s_nxt.code = quantize(lq.snr_mean);
      end else begin
        s_nxt.code = CODE_UNSUP;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lq.code_valid = s_r.vld;
  assign lq.code = s_r.code;

endmodule // lq_encoder

// ---- core/gap_counter.sv ----
// Loadable down counter that flags expiry
`timescale 1ns/100ps
module gap_counter
  import phy_timing_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i, // Start a count
  input wire logic [CNT_W-1:0] len_i, // Cycles to count
  output logic busy_o, // Counting
  output logic done_o // Pulse in the cycle the count reaches zero
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } cnt_state_t;

  cnt_state_t s_r; // Registered state
  cnt_state_t s_nxt; // Next state

  // Load wins over running count
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (load_i) begin
      s_nxt.cnt = len_i;
    end else if (s_r.cnt != CNT_ZERO) begin
      s_nxt.cnt = s_r.cnt - CNT_ONE;
      s_nxt.done = (s_r.cnt == CNT_ONE);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_o = (s_r.cnt != CNT_ZERO);
  assign done_o = s_r.done;

endmodule // gap_counter

// ---- core/phy_turnaround_lqe.sv ----
// Turnaround and frame spacing timer with link quality reporting
`timescale 1ns/100ps
module phy_turnaround_lqe
  import phy_timing_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic BURST_I, // Burst mode select
  input wire logic LQ_EN_I, // Quality reporting supported
  input wire logic RX_LAST_I, // Last received sample, pulse
  input wire logic TX_REQ_I, // MAC wants to transmit, level
  input wire logic TX_LAST_I, // Last transmitted sample, pulse
  input wire logic SNR_VALID_I, // Packet mean SNR ready, pulse
  input wire logic signed [SNR_W-1:0] SNR_MEAN_I, // dB, 4 fraction bits
  output logic TX_READY_O, // May emit first preamble sample
  output logic RX_READY_O, // Receiver armed
  output logic TX_START_O, // Pulse: start next transmission
  output logic LQ_VALID_O, // Pulse: new code
  output logic [7:0] LQ_CODE_O // Link quality code
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    link_state_t st;
    logic tx_ready;
    logic rx_ready;
    logic tx_start;
    logic lq_valid;
    logic [7:0] lq_code;
    logic burst;
  } top_state_t;

  top_state_t s_r; // Registered state
  top_state_t s_nxt; // Next state
  logic cnt_load; // Start a count
  logic [CNT_W-1:0] cnt_len; // Count length
  logic cnt_busy; // Counter running
  logic cnt_done; // Counter expired
  lq_if lq (); // Link to the encoder

  ////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  gap_counter u_gap (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .load_i(cnt_load),
    .len_i(cnt_len),
    .busy_o(cnt_busy),
    .done_o(cnt_done)
  );

  assign lq.snr_valid = SNR_VALID_I;
  assign lq.snr_mean = SNR_MEAN_I;
  assign lq.enable = LQ_EN_I;

  lq_encoder u_enc (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .lq(lq.enc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Direction and spacing control
  // Inputs come from same-clock baseband logic, so no synchronisers.
  // Burst select is sampled only when a gap starts, so a mid-gap change
  // cannot stretch or cut the running gap.
  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_start = 1'b0;
    s_nxt.lq_valid = lq.code_valid;
    cnt_load = 1'b0;
    cnt_len = TURN_CYC;
    if (lq.code_valid) begin
      s_nxt.lq_code = lq.code;
    end
    unique case (s_r.st)
      // Waiting, receiver armed
      ST_IDLE: begin
        s_nxt.rx_ready = 1'b1;
        if (TX_REQ_I) begin
          s_nxt.st = ST_RX2TX;
          s_nxt.rx_ready = 1'b0;
          cnt_load = 1'b1;
        end else if (RX_LAST_I) begin
          s_nxt.st = ST_RX;
        end
      end
      // Packet just received
      ST_RX: begin
        if (TX_REQ_I) begin
          s_nxt.st = ST_RX2TX;
          s_nxt.rx_ready = 1'b0;
          cnt_load = 1'b1;
        end else begin
          s_nxt.st = ST_IDLE;
        end
      end
      // Short fixed turnaround, well below the short spacing
      ST_RX2TX: begin
        if (cnt_done) begin
          s_nxt.st = ST_TX;
          s_nxt.tx_ready = 1'b1;
          s_nxt.tx_start = 1'b1;
        end
      end
      // Transmitting
      ST_TX: begin
        if (TX_LAST_I) begin
          s_nxt.tx_ready = 1'b0;
          s_nxt.burst = BURST_I;
          s_nxt.st = ST_GAP;
          cnt_load = 1'b1;
          // Gap counted from the last sample
          cnt_len = BURST_I ? MIN_GAP : SHORT_GAP;
        end
      end
      // Interframe gap; receiver armed at once unless in burst mode
      ST_GAP: begin
        if (cnt_busy && !s_r.burst) begin
          s_nxt.rx_ready = 1'b1;
        end
        if (cnt_done) begin
          if (TX_REQ_I) begin
            // Next transmission one gap plus two cycles after the last sample
            s_nxt.st = ST_TX;
            s_nxt.tx_ready = 1'b1;
            s_nxt.tx_start = 1'b1;
            s_nxt.rx_ready = 1'b0;
          end else begin
            s_nxt.st = ST_TX2RX;
          end
        end
      end
      // Back to receive
      ST_TX2RX: begin
        s_nxt.rx_ready = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign TX_READY_O = s_r.tx_ready;
  assign RX_READY_O = s_r.rx_ready;
  assign TX_START_O = s_r.tx_start;
  assign LQ_VALID_O = s_r.lq_valid;
  assign LQ_CODE_O = s_r.lq_code;

endmodule // phy_turnaround_lqe

// ---- sim/phy_far_end.sv ----
// Baseband far end: ends each transmission a set time after its start
`timescale 1ns/100ps
module phy_far_end (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i, // Transmission begins
  input wire logic [7:0] len_i, // Payload cycles, 1 is prompt
  output logic last_o // Pulse on final sample
);
  logic [7:0] cnt_r; // Cycles left
  // Count down and flag the final sample once; idle low between frames
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      last_o <= 1'b0;
    end else begin
      last_o <= (cnt_r == 8'h01);
      if (start_i) begin
        cnt_r <= len_i;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // phy_far_end

// ---- sim/phy_turnaround_lqe_chk.sv ----
// Port checks on turnaround timing and quality codes
`timescale 1ns/100ps
module phy_turnaround_lqe_chk
  import phy_timing_pkg::*;
(
  input logic CLK_I,
  input logic RSTN_I,
  input logic BURST_I,
  input logic LQ_EN_I,
  input logic TX_REQ_I,
  input logic TX_LAST_I,
  input logic SNR_VALID_I,
  input logic signed [SNR_W-1:0] SNR_MEAN_I,
  input logic TX_READY_O,
  input logic RX_READY_O,
  input logic TX_START_O,
  input logic LQ_VALID_O,
  input logic [7:0] LQ_CODE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////
  // Gap openings; last sample only counts while transmitting
  sequence last_n; TX_LAST_I && TX_READY_O && !BURST_I; endsequence
  sequence last_b; TX_LAST_I && TX_READY_O && BURST_I; endsequence
  sequence snr_en; SNR_VALID_I && LQ_EN_I; endsequence
  chk_code_range: assert property (LQ_CODE_O <= 8'h33)
    else $error("reserved code");
  chk_code_lat: assert property (SNR_VALID_I |-> ##2 LQ_VALID_O)
    else $error("code late");
  chk_code_hold: assert property (!LQ_VALID_O |-> $stable(LQ_CODE_O))
    else $error("code moved");
  chk_unsup_zero: assert property (SNR_VALID_I && !LQ_EN_I |->
    ##2 LQ_CODE_O == 8'h00) else $error("unsupported not zero");
  chk_clamp_low: assert property (snr_en ##0
    (SNR_MEAN_I < -12'sd152) |-> ##2 LQ_CODE_O == 8'h01) else $error("low");
  chk_clamp_high: assert property (snr_en ##0
    (SNR_MEAN_I >= 12'sd632) |-> ##2 LQ_CODE_O == 8'h33) else $error("high");
  chk_short_gap: assert property (last_n |->
    ##252 (TX_START_O || !TX_REQ_I)) else $error("normal gap");
  chk_gap_early: assert property (not (last_n ##[1:251] TX_START_O))
    else $error("early start");
  chk_burst_gap: assert property (last_b |->
    ##52 (TX_START_O || !TX_REQ_I)) else $error("burst gap");
  chk_rx_turn: assert property ($rose(TX_REQ_I) && RX_READY_O |->
    ##[1:249] TX_READY_O) else $error("slow rx turn");
  chk_tx_turn: assert property ($fell(TX_READY_O) && !BURST_I |->
    ##[1:249] RX_READY_O) else $error("slow tx turn");
endmodule // phy_turnaround_lqe_chk
bind phy_turnaround_lqe phy_turnaround_lqe_chk u_chk (.CLK_I(CLK_I),
  .RSTN_I(RSTN_I), .BURST_I(BURST_I), .LQ_EN_I(LQ_EN_I),
  .TX_REQ_I(TX_REQ_I), .TX_LAST_I(TX_LAST_I), .SNR_VALID_I(SNR_VALID_I),
  .SNR_MEAN_I(SNR_MEAN_I), .TX_READY_O(TX_READY_O),
  .RX_READY_O(RX_READY_O), .TX_START_O(TX_START_O),
  .LQ_VALID_O(LQ_VALID_O), .LQ_CODE_O(LQ_CODE_O));

// ---- sim/phy_turnaround_lqe_tb_top.sv ----
// Self-checking bench for turnaround timing and quality codes
`timescale 1ns/100ps
module phy_turnaround_lqe_tb_top;
  import phy_timing_pkg::*;
  logic CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic BURST_I = 1'b0;
  logic LQ_EN_I = 1'b0;
  logic TX_REQ_I = 1'b0;
  logic RX_LAST_I = 1'b0; // Last received sample pulse
  logic SNR_VALID_I = 1'b0;
  logic signed [SNR_W-1:0] SNR_MEAN_I = 12'h000;
  logic [7:0] plen = 8'h01; // Far end payload length
  logic TX_LAST_I, TX_READY_O, RX_READY_O, TX_START_O, LQ_VALID_O;
  logic [7:0] LQ_CODE_O;
  int error_cnt = 0;
  int comparisons = 0;
  always #20 CLK_I = ~CLK_I;
  // Receive-end pulse opens each turnaround before the request
  phy_turnaround_lqe u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .BURST_I(BURST_I), .LQ_EN_I(LQ_EN_I), .RX_LAST_I(RX_LAST_I),
    .TX_REQ_I(TX_REQ_I), .TX_LAST_I(TX_LAST_I), .SNR_VALID_I(SNR_VALID_I),
    .SNR_MEAN_I(SNR_MEAN_I), .TX_READY_O(TX_READY_O),
    .RX_READY_O(RX_READY_O), .TX_START_O(TX_START_O),
    .LQ_VALID_O(LQ_VALID_O), .LQ_CODE_O(LQ_CODE_O));
  phy_far_end u_far (.clk_i(CLK_I), .rstn_i(RSTN_I), .start_i(TX_START_O),
    .len_i(plen), .last_o(TX_LAST_I));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Expected code: add half a dB, floor, clamp, offset by 11
  function automatic logic [7:0] qexp(input logic signed [11:0] x,
                                      input logic en);
    int d;
    d = (int'(x) + 8) >>> 4;
    if (d < -10) d = -10;
    if (d > 40) d = 40;
    return en ? 8'(d + 11) : 8'h00;
  endfunction
  // One estimate in, code one edge after it is taken
  task automatic snr_one(input logic signed [11:0] x, input logic en);
    @(posedge CLK_I);
    SNR_VALID_I <= 1'b1;
    SNR_MEAN_I <= x;
    LQ_EN_I <= en;
    @(posedge CLK_I);
    SNR_VALID_I <= 1'b0;
    repeat (1) @(posedge CLK_I);
    #1;
    chk(LQ_VALID_O, 1'b1);
    chk(LQ_CODE_O, qexp(x, en));
  endtask
  // Both clamp edges, rounding ties, then reporting unsupported
  task automatic lq_table();
    logic signed [11:0] tbl [10] = '{12'he70, 12'hf67, 12'hf68, 12'h000,
      12'h007, 12'h008, 12'h0a0, 12'h277, 12'h278, 12'h7ff};
    foreach (tbl[i]) begin
      snr_one(tbl[i], 1'b1);
    end
    snr_one(12'h0a0, 1'b0);
  endtask
  // Count edges until start (m=0) or last sample (m=1), bounded
  task automatic wt(input bit m, output int n);
    n = 0;
    do begin
      @(posedge CLK_I);
      #1;
      n++;
    end while ((m ? TX_LAST_I : TX_START_O) !== 1'b1 && n < 400);
  endtask
  // Turnaround, one gap with request held, then a refused gap
  task automatic turn_case(input logic b, input logic [7:0] l, input int g);
    int n;
    @(posedge CLK_I);
    RX_LAST_I <= 1'b1;
    @(posedge CLK_I);
    RX_LAST_I <= 1'b0;
    TX_REQ_I <= 1'b1;
    BURST_I <= b;
    plen <= l;
    wt(1'b0, n);
    chk(n, 6);
    wt(1'b1, n);
    wt(1'b0, n);
    chk(n, g + 2);
    @(posedge CLK_I);
    TX_REQ_I <= 1'b0;
    wt(1'b1, n);
    wt(1'b0, n);
    chk(n, 400);
    chk(RX_READY_O, 1'b1);
  endtask
  initial begin
    repeat (3) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    lq_table();
    turn_case(1'b0, 8'h01, 10000 / 40);
    turn_case(1'b1, 8'h40, 2000 / 40);
    summarize();
  end
  // Watchdog at a few times the expected run length
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // phy_turnaround_lqe_tb_top
